// >>> bench/leis_ctrl_model.sv
// machine controller side: turns wanted control levels into opto pair outputs
// assumes one opto per polarity, as the input stage of the sequencer expects
`timescale 1ns/10ps
`default_nettype none
module leis_ctrl_model
  import leis_pkg::*;
(
  input  wire logic [leis_pkg::NUM_IN-1:0] level,
  input  wire logic [leis_pkg::NUM_IN-1:0] pol,
  output var  logic [leis_pkg::NUM_IN-1:0] in_pos,
  output var  logic [leis_pkg::NUM_IN-1:0] in_neg
);
  // ****************************************************************
  // opto outputs
  // ****************************************************************
  // a removed voltage lights neither opto, so both outputs go low
  always_comb
  begin
    in_pos = level & ~pol;
    in_neg = level & pol;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the laser enable interlock sequencer
// assumes leis_pkg, the interface and the rtl modules compile first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import leis_pkg::*;
  localparam int H = 16;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] lvl = 3'h1;
  logic [2:0] pol = 3'h0;
  logic [2:0] in_pos;
  logic [2:0] in_neg;
  logic       rf_power_en;
  logic       shutter_drive;
  logic       laser_ready;
  logic       shutter_open_indicator;
  logic       interlock_open;
  logic       lase_permit;
  int         bad_count = 0;
  int         checks_done = 0;
  int         n;
  // rows: polarity, level {shutter, interlock, disable}, {rf, shutter, ready, open}
  logic [9:0] rows [8] = '{10'h070, 10'h3f0, 10'h06e, 10'h3ee, 10'h12a, 10'h2c1, 10'h011, 10'h301};

  always #50 mclk = ~mclk;

  leis_ctrl_model leis_ctrl_model_inst (.level(lvl), .pol(pol), .in_pos(in_pos), .in_neg(in_neg));
  leis_top #(.HOLDOFF_CYCLES(H)) leis_top_inst (
    .mclk                   (mclk),
    .rst                    (rst),
    .in_pos                 (in_pos),
    .in_neg                 (in_neg),
    .rf_power_en            (rf_power_en),
    .shutter_drive          (shutter_drive),
    .laser_ready            (laser_ready),
    .shutter_open_indicator (shutter_open_indicator),
    .interlock_open         (interlock_open),
    .lase_permit            (lase_permit)
  );

  // ****************************************************************
  // compare and wait helpers
  // ****************************************************************
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %b seen %b", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic chk_n(input string name, input int exp, input int got);
    checks_done++;
    if (got != exp)
    begin
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic settle;
    repeat (6) @(negedge mclk);
  endtask

  task automatic outs(input logic [3:0] e);
    chk("rf_power_en", e[3], rf_power_en);
    chk("shutter_drive", e[2], shutter_drive);
    chk("shutter_open_indicator", e[2], shutter_open_indicator);
    chk("laser_ready", e[1], laser_ready);
    chk("interlock_open", e[0], interlock_open);
  endtask

  // hold-off is counted from the cycle ready lights; a hang cuts the run short
  task automatic measure;
    n = 0;
    while (laser_ready !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20)
    begin
      bad_count++;
      final_report();
    end
    n = 0;
    while (lase_permit !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    // ready lights on the edge that enters hold-off; permit follows exactly H edges later
    chk_n("holdoff cycles", H, n);
    if (n >= 100)
      final_report();
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(negedge mclk);
    outs(4'h0);
    chk("lase_permit", 1'b0, lase_permit);
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      pol = rows[i][9:7];
      lvl = 3'h1;
      settle();
      lvl = rows[i][6:4];
      settle();
      outs(rows[i][3:0]);
      chk("lase_permit", 1'b0, lase_permit);
    end
    pol = 3'h5;
    lvl = 3'h7;
    settle();
    lvl = 3'h6;
    measure();
    for (int ch = 0; ch < 2; ch++)
    begin
      lvl = 3'h7;
      settle();
      lvl = 3'h6;
      repeat (8) @(negedge mclk);
      lvl = (ch == 0) ? 3'h7 : 3'h4;
      settle();
      chk("rf_power_en", 1'b0, rf_power_en);
      chk("lase_permit", 1'b0, lase_permit);
      lvl = 3'h6;
      measure();
    end
    lvl = 3'h2;
    settle();
    outs(4'ha);
    chk("lase_permit", 1'b0, lase_permit);
    lvl = 3'h6;
    settle();
    chk("lase_permit", 1'b1, lase_permit);
    lvl = 3'h4;
    settle();
    outs(4'h1);
    chk("lase_permit", 1'b0, lase_permit);
    lvl = 3'h6;
    measure();
    chk("interlock_open", 1'b0, interlock_open);
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    outs(4'h0);
    chk("lase_permit", 1'b0, lase_permit);
    rst = 1'b0;
    // inputs stay released across the reset, so a full fresh hold-off must follow
    measure();
    final_report();
  end
endmodule
`default_nettype wire

// >>> rtl/leis_cond_if.sv
// conditioned control levels passed from the input stage to the sequencer
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface leis_cond_if;
  logic remote_disable;
  logic interlock;
  logic shutter_req;

  modport src (output remote_disable, output interlock, output shutter_req);
  modport snk (input remote_disable, input interlock, input shutter_req);
endinterface
`default_nettype wire

// >>> rtl/leis_in_cond.sv
// input stage: synchronises each opto pair and merges both polarities
// assumes the opto outputs are asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module leis_in_cond
  import leis_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [leis_pkg::NUM_IN-1:0]   in_pos,
  input  wire logic [leis_pkg::NUM_IN-1:0]   in_neg,
  leis_cond_if.src                           cond
);

  logic [NUM_IN-1:0] pos_s1;
  logic [NUM_IN-1:0] pos_s2;
  logic [NUM_IN-1:0] neg_s1;
  logic [NUM_IN-1:0] neg_s2;
  logic [NUM_IN-1:0] asserted;

  // ****************************************************************
  // two-stage synchronisers, one per opto output
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NUM_IN; i++)
    begin : g_ch
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          pos_s1[i]   <= 1'b0;
          pos_s2[i]   <= 1'b0;
          neg_s1[i]   <= 1'b0;
          neg_s2[i]   <= 1'b0;
          asserted[i] <= 1'b0;
        end
        else
        begin
          pos_s1[i]   <= in_pos[i];
          pos_s2[i]   <= pos_s1[i];
          neg_s1[i]   <= in_neg[i];
          neg_s2[i]   <= neg_s1[i];
          asserted[i] <= pos_s2[i] | neg_s2[i];
        end
      end

      AST_EITHER_POLARITY: assert property (@(posedge mclk) disable iff (rst)
        (in_pos[i] || in_neg[i]) [*3] |-> ##1 asserted[i])
        else $error("asserted input of either polarity not recognised");
    end
  endgenerate

  assign cond.remote_disable = asserted[CH_DISABLE];
  assign cond.interlock      = asserted[CH_INTLK];
  assign cond.shutter_req    = asserted[CH_SHUTREQ];

endmodule
`default_nettype wire

// >>> rtl/leis_pkg.sv
// constants shared by the laser enable interlock sequencer
// assumes a single 10 MHz clock and opto-isolated control inputs
package leis_pkg;

  // ****************************************************************
  // input channels, each seen through a pair of opto outputs
  // ****************************************************************
  localparam int unsigned NUM_IN     = 3;
  localparam int unsigned CH_DISABLE = 0;
  localparam int unsigned CH_INTLK   = 1;
  localparam int unsigned CH_SHUTREQ = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned HOLDOFF_MS    = 5000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned HOLDOFF_CYC   = (CLK_HZ / MS_PER_S) * HOLDOFF_MS;
  localparam int unsigned CNT_W         = 26;
  localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 26'h0000001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 26'h3ffffff;

  typedef enum logic [1:0] {
    LEIS_DISABLED,
    LEIS_HOLDOFF,
    LEIS_ENABLED
  } leis_state_t;

endpackage

// >>> rtl/leis_top.sv
// laser enable interlock sequencer: gates rf power, shutter and indicators
// assumes opto pairs on the pins and a power-on reset from the board
`timescale 1ns/10ps
`default_nettype none
module leis_top
  import leis_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = leis_pkg::HOLDOFF_CYC
)
(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [leis_pkg::NUM_IN-1:0]   in_pos,
  input  wire logic [leis_pkg::NUM_IN-1:0]   in_neg,
  output var  logic                          rf_power_en,
  output var  logic                          shutter_drive,
  output var  logic                          laser_ready,
  output var  logic                          shutter_open_indicator,
  output var  logic                          interlock_open,
  output var  logic                          lase_permit
);

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLDOFF_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_FULL = CNT_W'(HOLDOFF_CYCLES);

  leis_cond_if cond ();

  leis_state_t      state;
  leis_state_t      next_state;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] next_hold_cnt;
  logic             release_ok;
  logic             next_shutter;
  logic [CNT_W-1:0] ready_age;

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  leis_in_cond u_cond (
    .mclk   (mclk),
    .rst    (rst),
    .in_pos (in_pos),
    .in_neg (in_neg),
    .cond   (cond)
  );

  // both the remote release and the interlock are needed before anything arms
  assign release_ok   = !cond.remote_disable && cond.interlock;
  assign next_shutter = release_ok && cond.shutter_req;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb
  begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    case (state)
      LEIS_DISABLED:
      begin
        next_hold_cnt = CNT_ZERO;
        if (release_ok)
          next_state = LEIS_HOLDOFF;
      end
      LEIS_HOLDOFF:
      begin
        if (!release_ok)
        begin
          next_state    = LEIS_DISABLED;
          next_hold_cnt = CNT_ZERO;
        end
        else if (hold_cnt >= HOLD_LAST)
          next_state = LEIS_ENABLED;
        else
          next_hold_cnt = hold_cnt + CNT_ONE;
      end
      LEIS_ENABLED:
      begin
        if (!release_ok)
          next_state = LEIS_DISABLED;
      end
      default:
      begin
        next_state    = LEIS_DISABLED;
        next_hold_cnt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state    <= LEIS_DISABLED;
      hold_cnt <= CNT_ZERO;
    end
    else
    begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ****************************************************************
  // outputs, all registered; only ready and permit from the next state
  // ****************************************************************
  // power is cut in the same edge that disables, so a glitching pin never
  // leaves the rf stage live for an extra cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rf_power_en <= 1'b0;
      laser_ready <= 1'b0;
    end
    else
    begin
      rf_power_en <= release_ok;
      laser_ready <= (next_state != LEIS_DISABLED);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      shutter_drive          <= 1'b0;
      shutter_open_indicator <= 1'b0;
    end
    else
    begin
      shutter_drive          <= next_shutter;
      shutter_open_indicator <= next_shutter;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interlock_open <= 1'b0;
      lase_permit    <= 1'b0;
    end
    else
    begin
      interlock_open <= !cond.interlock;
      lase_permit    <= (next_state == LEIS_ENABLED) && next_shutter;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // age of the current ready period, only for the hold-off check
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ready_age <= CNT_ZERO;
    else if (!laser_ready)
      ready_age <= CNT_ZERO;
    else if (ready_age != CNT_MAX)
      ready_age <= ready_age + CNT_ONE;
  end

  sequence s_intlk_drop;
    $fell(cond.interlock);
  endsequence

  sequence s_all_off;
    !shutter_drive && !shutter_open_indicator && !laser_ready && !rf_power_en;
  endsequence

  sequence s_release;
    $fell(cond.remote_disable) && cond.interlock;
  endsequence

  AST_DISABLE_HOLDS: assert property (@(posedge mclk) disable iff (rst)
    cond.remote_disable |=> !lase_permit && !laser_ready)
    else $error("laser not held disabled under remote disable");

  AST_READY_ON_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    s_release |=> laser_ready && !lase_permit && (hold_cnt == CNT_ZERO))
    else $error("ready or countdown not started on release");

  AST_RF_OFF_DISABLE: assert property (@(posedge mclk) disable iff (rst)
    cond.remote_disable |=> !rf_power_en)
    else $error("rf power on while remote disable asserted");

  AST_RF_OFF_INTLK: assert property (@(posedge mclk) disable iff (rst)
    !cond.interlock |=> !rf_power_en && !lase_permit)
    else $error("rf power on while interlock open");

  AST_FAULT_NOT_LATCHED: assert property (@(posedge mclk) disable iff (rst)
    cond.interlock ##1 cond.interlock |=> !interlock_open)
    else $error("interlock fault stays shown after interlock returned");

  AST_LASE_NEEDS_SHUTTER: assert property (@(posedge mclk) disable iff (rst)
    lase_permit |-> shutter_open_indicator && laser_ready)
    else $error("lasing permitted without shutter open");

  AST_INTLK_DROP_CLOSES: assert property (@(posedge mclk) disable iff (rst)
    s_intlk_drop |=> s_all_off)
    else $error("interlock loss did not close shutter and cut power");

  AST_HOLDOFF_ELAPSED: assert property (@(posedge mclk) disable iff (rst)
    lase_permit |-> ready_age >= HOLD_FULL)
    else $error("lasing permitted before hold-off elapsed");

  AST_INTLK_STATUS: assert property (@(posedge mclk) disable iff (rst)
    interlock_open |-> !lase_permit && !$past(cond.interlock))
    else $error("interlock open status wrong");

  AST_SHUTTER_NEEDS_BOTH: assert property (@(posedge mclk) disable iff (rst)
    shutter_drive |-> $past(cond.interlock) && $past(cond.shutter_req))
    else $error("shutter opened without request and interlock");

  AST_ABANDON_COUNT: assert property (@(posedge mclk) disable iff (rst)
    (state == LEIS_HOLDOFF) && !release_ok |=> (state == LEIS_DISABLED) && (hold_cnt == CNT_ZERO))
    else $error("countdown not abandoned on loss of release");

endmodule
`default_nettype wire
